// *** core/csia_consts.svh ***
/*
  Constants for the core stack and indexed addressing support block.
  Assumes inclusion by the package, the core module, the checker and the bench.
*/
// Contract
// - with fault reset enabled, full or underflow sets its flag then resets device
// - with fault reset disabled, full or underflow sets flag only, no reset
// - overflow and underflow flags stay set until software clear or power-on reset
// - push increments pointer and writes program counter into new top entry
// - pop decrements pointer, previous pushed value becomes top of stack
// - top entry readable and writable through upper, high and low bytes
// - one-level shadow captures status, working, bank select on every interrupt vector
// - fast interrupt return restores status, working and bank select from shadow
// - shadow restore keeps watchdog-expired and power-down status bits unchanged
// - fast call saves three registers to shadow, fast return restores them
// - high priority entry overwrites low priority shadow values, no nesting guard
// - indirect read of another indirect port through a pointer returns zero
// - indirect write of another indirect port through a pointer does nothing
// - writing pointer pair through its own virtual ports stores value unmodified; the code flags this for pointer pair two only
// - indexed literal offset needs extended set, access bank forced, address up to 5fh
// - indexed mode adds file address offset to pointer pair two
// - bank bit one or address 60h and above uses normal addressing
// - extended set leaves pointer pairs zero and one indirect addressing unchanged
// - inherent and literal instructions unaffected by extended set
`ifndef CSIA_CONSTS_SVH
`define CSIA_CONSTS_SVH
`define CSIA_STACK_DEPTH      31
`define CSIA_PTR_W            5
`define CSIA_PC_W             21
`define CSIA_IDX_LIMIT        8'h5f
`define CSIA_STATUS_TO_BIT    4
`define CSIA_STATUS_PD_BIT    3
`define CSIA_IND0_ADDR        12'hfef
`define CSIA_IND1_ADDR        12'hfe7
`define CSIA_IND2_ADDR        12'hfdf
`define CSIA_POST_DECREMENT_PORT_TWO_ADDR    12'hfdd
`define CSIA_POSTINC2_ADDR    12'hfde
`define CSIA_PREINC2_ADDR     12'hfdc
`define CSIA_PLUSW2_ADDR      12'hfdb
`endif

// *** core/csia_core.sv ***
/*
  Return stack, shadow register stack, indirect port corner cases and
  indexed literal offset address generation for an 8-bit core.
  Assumes one instruction strobe per cycle from the core sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csia_consts.svh"
module csia_core
  import csia_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   por_in,
  input  wire logic                   stack_fault_reset_enable_in,
  input  wire logic                   extended_isa_enable_in,
  input  wire logic                   push_in,
  input  wire logic                   pop_in,
  input  wire logic [`CSIA_PC_W-1:0]  pc_in,
  input  wire logic                   tos_wr_upper_in,
  input  wire logic                   tos_wr_high_in,
  input  wire logic                   tos_wr_low_in,
  input  wire logic [7:0]             tos_wdata_in,
  input  wire logic                   flag_clr_full_in,
  input  wire logic                   flag_clr_underflow_in,
  input  wire logic                   int_vector_in,
  input  wire logic                   fast_call_in,
  input  wire logic                   fast_return_in,
  input  wire logic [7:0]             status_in,
  input  wire logic [7:0]             working_register_in,
  input  wire logic [7:0]             bank_select_register_in,
  input  wire logic                   mem_access_in,
  input  wire logic                   direct_in,
  input  wire logic                   access_bit_in,
  input  wire logic [7:0]             file_addr_in,
  input  wire logic [15:0]            pointer_pair_two_in,
  input  wire logic [1:0]             ind_sel_in,
  input  wire logic [15:0]            ind_ptr_in,
  input  wire logic                   ind_write_in,
  input  wire logic [7:0]             ind_rdata_in,
  output logic [`CSIA_PC_W-1:0]       top_of_stack_out,
  output logic [`CSIA_PTR_W-1:0]      stack_ptr_out,
  output logic                        stack_full_flag_out,
  output logic                        stack_underflow_flag_out,
  output logic                        stack_reset_req_out,
  output logic                        restore_valid_out,
  output logic [7:0]                  status_out,
  output logic [7:0]                  working_register_out,
  output logic [7:0]                  bank_select_register_out,
  output logic [15:0]                 operand_addr_out,
  output logic                        indexed_out,
  output logic                        ind_write_en_out,
  output logic [7:0]                  ind_rdata_out,
  output logic                        ptr_raw_write_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic is_ind_port(input logic [11:0] a);
    is_ind_port = (a == `CSIA_IND0_ADDR) || (a == `CSIA_IND1_ADDR) || (a == `CSIA_IND2_ADDR);
  endfunction

  function automatic logic is_ptr2_port(input logic [11:0] a);
    is_ptr2_port = (a == `CSIA_IND2_ADDR) || (a == `CSIA_POST_DECREMENT_PORT_TWO_ADDR) || (a == `CSIA_POSTINC2_ADDR)
                   || (a == `CSIA_PREINC2_ADDR) || (a == `CSIA_PLUSW2_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  logic [`CSIA_PC_W-1:0]  stack_mem [1:`CSIA_STACK_DEPTH];
  logic [`CSIA_PTR_W-1:0] sp;
  logic                   full_flag;
  logic                   unf_flag;
  wire logic              stack_full   = (sp == `CSIA_PTR_W'(`CSIA_STACK_DEPTH));
  wire logic              stack_empty  = (sp == '0);
  wire logic              push_ok      = push_in && !stack_full;
  wire logic              pop_ok       = pop_in && !push_in && !stack_empty;
  wire logic              full_event   = push_in && stack_full;
  wire logic              unf_event    = pop_in && !push_in && stack_empty;
  wire logic [`CSIA_PTR_W-1:0] next_sp = push_ok ? sp + 1'b1 : (pop_ok ? sp - 1'b1 : sp);
  wire logic [`CSIA_PC_W-1:0]  tos_cur = stack_empty ? '0 : stack_mem[sp];

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sp <= '0;
    else
      sp <= next_sp;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (push_ok)
      stack_mem[sp + 1'b1] <= pc_in;
    else if (!stack_empty)
    begin
      if (tos_wr_upper_in)
        stack_mem[sp][`CSIA_PC_W-1:16] <= tos_wdata_in[`CSIA_PC_W-17:0];
      if (tos_wr_high_in)
        stack_mem[sp][15:8] <= tos_wdata_in;
      if (tos_wr_low_in)
        stack_mem[sp][7:0] <= tos_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // fault flags: event wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      full_flag <= 1'b0;
      unf_flag  <= 1'b0;
    end
    else if (por_in)
    begin
      full_flag <= 1'b0;
      unf_flag  <= 1'b0;
    end
    else
    begin
      full_flag <= full_event | (full_flag & ~flag_clr_full_in);
      unf_flag  <= unf_event | (unf_flag & ~flag_clr_underflow_in);
    end
  end

  // reset request follows the flag by one cycle
  logic fault_d;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fault_d             <= 1'b0;
      stack_reset_req_out <= 1'b0;
    end
    else
    begin
      fault_d             <= (full_event | unf_event) & stack_fault_reset_enable_in;
      stack_reset_req_out <= fault_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stack_ptr_out            <= '0;
      top_of_stack_out         <= '0;
      stack_full_flag_out      <= 1'b0;
      stack_underflow_flag_out <= 1'b0;
    end
    else
    begin
      stack_ptr_out            <= sp;
      top_of_stack_out         <= tos_cur;
      stack_full_flag_out      <= full_flag;
      stack_underflow_flag_out <= unf_flag;
    end
  end

  // ----------------------------------------------------------------
  // shadow register stack
  // ----------------------------------------------------------------
  logic [7:0] sh_status;
  logic [7:0] sh_work;
  logic [7:0] sh_bank;
  wire csia_fast_op_t fast_op = (int_vector_in || fast_call_in) ? CSIA_FR_SAVE
                              : (fast_return_in ? CSIA_FR_LOAD : CSIA_FR_NONE);
  wire logic [7:0] keep_mask  = (8'h01 << `CSIA_STATUS_TO_BIT) | (8'h01 << `CSIA_STATUS_PD_BIT);
  wire logic [7:0] next_status = (sh_status & ~keep_mask) | (status_in & keep_mask);

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sh_status <= '0;
      sh_work   <= '0;
      sh_bank   <= '0;
    end
    else if (fast_op == CSIA_FR_SAVE)
    begin
      sh_status <= status_in;
      sh_work   <= working_register_in;
      sh_bank   <= bank_select_register_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      restore_valid_out        <= 1'b0;
      status_out               <= '0;
      working_register_out     <= '0;
      bank_select_register_out <= '0;
    end
    else
    begin
      restore_valid_out <= (fast_op == CSIA_FR_LOAD);
      if (fast_op == CSIA_FR_LOAD)
      begin
        status_out               <= next_status;
        working_register_out     <= sh_work;
        bank_select_register_out <= sh_bank;
      end
    end
  end

  // ----------------------------------------------------------------
  // operand address: indexed literal offset vs normal
  // ----------------------------------------------------------------
  wire logic use_indexed = extended_isa_enable_in && mem_access_in && direct_in
                           && !access_bit_in && (file_addr_in <= `CSIA_IDX_LIMIT);
  wire logic [15:0] idx_addr  = pointer_pair_two_in + {8'h00, file_addr_in};
  wire logic [15:0] acc_addr  = (file_addr_in > `CSIA_IDX_LIMIT) ? {8'h0f, file_addr_in} : {8'h00, file_addr_in};
  wire logic [15:0] norm_addr = access_bit_in ? {bank_select_register_in, file_addr_in} : acc_addr;
  wire logic [15:0] sel_addr  = !direct_in ? ind_ptr_in : (use_indexed ? idx_addr : norm_addr);

  // ----------------------------------------------------------------
  // indirect port corner cases
  // ----------------------------------------------------------------
  wire logic ind_active = mem_access_in && !direct_in;
  wire logic ind_nested = ind_active && is_ind_port(ind_ptr_in[11:0]);
  wire logic ptr_self   = ind_active && ind_write_in && (ind_sel_in == 2'd2)
                          && is_ptr2_port(ind_ptr_in[11:0]);

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      operand_addr_out  <= '0;
      indexed_out       <= 1'b0;
      ind_write_en_out  <= 1'b0;
      ind_rdata_out     <= '0;
      ptr_raw_write_out <= 1'b0;
    end
    else
    begin
      operand_addr_out  <= sel_addr;
      indexed_out       <= use_indexed;
      ind_write_en_out  <= mem_access_in && ind_write_in && !ind_nested;
      ind_rdata_out     <= ind_nested ? 8'h00 : ind_rdata_in;
      ptr_raw_write_out <= ptr_self;
    end
  end

endmodule
`default_nettype wire

// *** core/csia_pkg.sv ***
/*
  Types for the core stack and indexed addressing support block.
  Assumes the constants header is available on the include path.
*/
`include "csia_consts.svh"
package csia_pkg;
  typedef enum logic [1:0] {
    CSIA_FR_NONE = 2'b00,
    CSIA_FR_SAVE = 2'b01,
    CSIA_FR_LOAD = 2'b10
  } csia_fast_op_t;
endpackage

// *** test/csia_core_chk.sv ***
/*
  Port checker for csia_core: stack faults, shadow restore, indirect and indexed addressing.
  Assumes it is bound into csia_core, whose ports carry the same names.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csia_consts.svh"
module csia_core_chk (
  input wire logic        ref_clk_in, reset_n_in, por_in, stack_fault_reset_enable_in, push_in, pop_in,
  input wire logic        extended_isa_enable_in, flag_clr_full_in, int_vector_in, fast_call_in, fast_return_in,
  input wire logic        mem_access_in, direct_in, access_bit_in, ind_write_in,
  input wire logic [7:0]  status_in, file_addr_in, status_out, ind_rdata_out,
  input wire logic [15:0] pointer_pair_two_in, ind_ptr_in, operand_addr_out,
  input wire logic [1:0]  ind_sel_in,
  input wire logic        stack_full_flag_out, stack_underflow_flag_out, stack_reset_req_out, restore_valid_out,
  input wire logic        indexed_out, ind_write_en_out, ptr_raw_write_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // indirect access through pointer zero or one that lands on an indirect port
  wire logic ind_cyc = mem_access_in && !direct_in && ind_sel_in != 2'd2;
  wire logic port_hit = ind_ptr_in == {4'h0, `CSIA_IND0_ADDR} || ind_ptr_in == {4'h0, `CSIA_IND1_ADDR}
    || ind_ptr_in == {4'h0, `CSIA_IND2_ADDR};
  wire logic [1:0] keep_in = {status_in[`CSIA_STATUS_TO_BIT], status_in[`CSIA_STATUS_PD_BIT]};
  wire logic [1:0] keep_out = {status_out[`CSIA_STATUS_TO_BIT], status_out[`CSIA_STATUS_PD_BIT]};
  AST_FULL_CAUSE: assert property ($rose(stack_full_flag_out) |-> $past(push_in, 2))
    else $error("full flag rose without push");
  AST_REQ_CAUSE: assert property (stack_reset_req_out |-> $past(stack_fault_reset_enable_in, 2))
    else $error("reset request while disabled");
  AST_REQ_PULSE: assert property ($rose(stack_underflow_flag_out) && $past(stack_fault_reset_enable_in, 2)
    |-> stack_reset_req_out ##1 !stack_reset_req_out) else $error("fault reset pulse wrong");
  AST_FULL_HOLD: assert property ($fell(stack_full_flag_out)
    |-> $past(flag_clr_full_in, 2) || por_in || $past(por_in) || $past(por_in, 2)) else $error("full flag lost");
  AST_RESTORE: assert property (fast_return_in && !int_vector_in && !fast_call_in |=> restore_valid_out)
    else $error("no restore");
  AST_KEEP_BITS: assert property (restore_valid_out |-> keep_out == $past(keep_in))
    else $error("timeout or powerdown bit restored");
  AST_INDEXED: assert property (mem_access_in && direct_in && extended_isa_enable_in && !access_bit_in
    && file_addr_in <= `CSIA_IDX_LIMIT |=> indexed_out && operand_addr_out == 16'($past(pointer_pair_two_in)
    + $past(file_addr_in))) else $error("indexed address wrong");
  AST_NORMAL: assert property (mem_access_in && direct_in && (access_bit_in || !extended_isa_enable_in
    || file_addr_in > `CSIA_IDX_LIMIT) |=> !indexed_out) else $error("indexed mode taken");
  AST_IND_READ: assert property (ind_cyc && port_hit && !ind_write_in |=> ind_rdata_out == 8'h00)
    else $error("port read not zero");
  AST_IND_WRITE: assert property (ind_cyc && port_hit && ind_write_in |=> !ind_write_en_out)
    else $error("port write not dropped");
  AST_RAW_WRITE: assert property (mem_access_in && !direct_in && ind_write_in && ind_sel_in == 2'd2
    && ind_ptr_in == {4'h0, `CSIA_POST_DECREMENT_PORT_TWO_ADDR} |=> ptr_raw_write_out) else $error("no raw pointer write");
endmodule
bind csia_core csia_core_chk i_csia_core_chk (.*);
`default_nettype wire

// *** test/csia_core_test.sv ***
/*
  Self-checking bench for csia_core: return stack, fault flags, shadow stack, addressing.
  Assumes the checker file is compiled with it and binds itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csia_consts.svh"
module csia_core_test;
  logic ref_clk_in, reset_n_in, por_in, stack_fault_reset_enable_in, extended_isa_enable_in, push_in, pop_in;
  logic tos_wr_upper_in, tos_wr_high_in, tos_wr_low_in, int_vector_in, fast_call_in, fast_return_in;
  logic flag_clr_full_in, flag_clr_underflow_in, ind_write_in, mem_access_in, direct_in, access_bit_in;
  logic indexed_out, ind_write_en_out, ptr_raw_write_out, stack_full_flag_out, stack_underflow_flag_out;
  logic stack_reset_req_out, restore_valid_out;
  logic [20:0] pc_in, top_of_stack_out;
  logic [4:0] stack_ptr_out;
  logic [7:0] tos_wdata_in, status_in, working_register_in, bank_select_register_in, file_addr_in, ind_rdata_in;
  logic [7:0] status_out, working_register_out, bank_select_register_out, ind_rdata_out, s, w, b;
  logic [15:0] pointer_pair_two_in, ind_ptr_in, operand_addr_out;
  logic [1:0] ind_sel_in;
  logic [31:0] n;
  logic [20:0] stk [$];
  int err_total = 0, cmp_count = 0, req_cnt = 0, seed, i, k;
  csia_core i_csia_core (.*);
  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
    if (stack_reset_req_out === 1'b1)
      req_cnt <= req_cnt + 1;
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("BAD %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_total++;
  endtask
  // b: 0 push 1 pop 2..4 top bytes 5 vector 6 fast call 7 fast return 8..9 flag clears 10 power-on
  task automatic op(input int b, input logic [20:0] d);
    @(posedge ref_clk_in);
    {push_in, pop_in, tos_wr_upper_in, tos_wr_high_in, tos_wr_low_in, int_vector_in, fast_call_in, fast_return_in,
     flag_clr_full_in, flag_clr_underflow_in, por_in} <= 11'h400 >> b;
    pc_in <= d;
    tos_wdata_in <= d[7:0];
    @(posedge ref_clk_in);
    {push_in, pop_in, tos_wr_upper_in, tos_wr_high_in, tos_wr_low_in, int_vector_in, fast_call_in, fast_return_in,
     flag_clr_full_in, flag_clr_underflow_in, por_in} <= 11'h000;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask
  function automatic logic [20:0] tos_exp(input logic [20:0] t, input int k, input logic [7:0] d);
    logic [23:0] x;
    x = {3'h0, t} & ~(24'hff << (8 * (2 - k)));
    x = x | ({16'h0, d} << (8 * (2 - k)));
    return x[20:0];
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    seed = 95594;
    reset_n_in = 1'b0;
    {por_in, stack_fault_reset_enable_in, extended_isa_enable_in, push_in, pop_in, tos_wr_upper_in, tos_wr_high_in,
     tos_wr_low_in, int_vector_in, fast_call_in, fast_return_in, flag_clr_full_in, flag_clr_underflow_in,
     ind_write_in, mem_access_in, direct_in, access_bit_in, pc_in, tos_wdata_in, status_in, working_register_in,
     bank_select_register_in, file_addr_in, ind_rdata_in, pointer_pair_two_in, ind_ptr_in, ind_sel_in} = '0;
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 32; i++)
    begin
      n = $random(seed);
      op(0, n[20:0]);
      if (stk.size() < 31)
        stk.push_back(n[20:0]);
      chk(21'(stack_ptr_out), 21'(stk.size()));
      chk(top_of_stack_out, stk[30 - (31 - stk.size())]);
    end
    chk(stack_full_flag_out, 1'b1);
    for (k = 0; k < 3; k++)
    begin
      n = $random(seed);
      op(2 + k, n[20:0]);
      stk[30] = tos_exp(stk[30], k, n[7:0]);
      chk(top_of_stack_out, stk[30]);
    end
    while (stk.size() > 0)
    begin
      void'(stk.pop_back());
      op(1, 21'h0);
      chk(21'(stack_ptr_out), 21'(stk.size()));
      chk(top_of_stack_out, stk.size() > 0 ? stk[stk.size() - 1] : 21'h0);
    end
    op(1, 21'h0);
    chk(stack_underflow_flag_out, 1'b1);
    chk(stack_full_flag_out, 1'b1);
    chk(21'(req_cnt), 21'h0);
    op(8, 21'h0);
    chk({stack_full_flag_out, stack_underflow_flag_out}, 2'b01);
    op(9, 21'h0);
    chk(stack_underflow_flag_out, 1'b0);
    stack_fault_reset_enable_in <= 1'b1;
    op(1, 21'h0);
    chk({stack_underflow_flag_out, 20'(req_cnt)}, {1'b1, 20'h1});
    op(10, 21'h0);
    chk(stack_underflow_flag_out, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      for (i = 0; i < 2; i++)
      begin
        n = $random(seed);
        {b, w, s} = n[23:0];
        {bank_select_register_in, working_register_in, status_in} <= n[23:0];
        op(5 + k, 21'h0);
      end
      n = $random(seed);
      {bank_select_register_in, working_register_in, status_in} <= n[23:0];
      op(7, 21'h0);
      chk({status_out, working_register_out, bank_select_register_out}, {s[7:5], n[4:3], s[2:0], w, b});
    end
    mem_access_in <= 1'b1;
    direct_in <= 1'b1;
    for (i = 0; i < 60; i++)
    begin
      n = $random(seed);
      @(posedge ref_clk_in);
      {extended_isa_enable_in, access_bit_in} <= i < 4 ? 2'b10 : n[1:0];
      file_addr_in <= i < 4 ? 8'(8'h5e + i) : n[15:8];
      pointer_pair_two_in <= n[31:16];
      @(posedge ref_clk_in);
      #1;
      chk(indexed_out, extended_isa_enable_in && !access_bit_in && file_addr_in <= 8'h5f);
      if (indexed_out === 1'b1)
        chk(operand_addr_out, 16'(pointer_pair_two_in + file_addr_in));
      else
        chk(operand_addr_out, access_bit_in ? {bank_select_register_in, file_addr_in}
            : {(file_addr_in > 8'h5f) ? 8'h0f : 8'h00, file_addr_in});
    end
    direct_in <= 1'b0;
    for (i = 0; i < 18; i++)
    begin
      n = $random(seed);
      @(posedge ref_clk_in);
      ind_sel_in <= i > 15 ? 2'd2 : {1'b0, i[3]};
      ind_ptr_in <= i > 15 ? 16'h0fdd : i[1:0] == 2'd3 ? 16'h0123 : 16'h0fef - 16'(8 * i[1:0]);
      ind_write_in <= i > 15 || i[2];
      ind_rdata_in <= n[7:0];
      @(posedge ref_clk_in);
      #1;
      chk(operand_addr_out, ind_ptr_in);
      if (i > 15)
        chk(ptr_raw_write_out, 1'b1);
      else if (i[2])
        chk(ind_write_en_out, i[1:0] == 2'd3);
      else
        chk(ind_rdata_out, i[1:0] == 2'd3 ? n[7:0] : 8'h00);
    end
    final_report();
  end
endmodule
`default_nettype wire
